// file: hdl/lpc_defines.svh
// register offsets, field positions and reset values of the low power controller
// Functional notes
// - separate divide ratios for system, peripheral, external bus and flash clocks
// - software picks running bus clock or constant high on bus clock pin
// - per-module stop bit: 1 stops the module, 0 releases it
// - program registers then execute standby instruction; mode chosen at that instruction
// - sleep, clock stop, standby end by interrupt or reset; resume via interrupt
// - deep standby cancellation resumes through reset processing, not interrupt service
// - units allowed to run in a mode follow their own control setting
// - retained stop freezes a unit, keeps registers, resumes from them
// - undefined stop removes power; contents lost until reinitialised
// - deep cut field selects RAM kept or lost in deep standby
// - deep cut field enables USB resume detect; only that unit retained
// - three operating power modes apply in normal, sleep and clock stop
// - entering a mode stops CPU, modules or oscillators as selected
// - independent watchdog and oscillator may run except deep standby, lost there
// - voltage detector may run, power-on reset operates in every mode
// - USB runs in sleep, stops in clock stop/standby, deep per deep cut
// - 8-bit timers run in sleep/clock stop, retained in standby, lost deep
// - RAM stop bit stops RAM from 0000 0000h to 0000 FFFFh
// - serial data and clock wake sources each enabled; enabled edge wakes deep standby
// - each fired deep wake source sets its own cancellation flag
// - each pin wake source has an edge select bit
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH
`define LPC_ADDR_W 4
`define LPC_OFF_STOP_A 4'h0
`define LPC_OFF_STOP_B 4'h1
`define LPC_OFF_STOP_C 4'h2
`define LPC_OFF_DEEP_CTRL 4'h3
`define LPC_OFF_WAKE_EN 4'h4
`define LPC_OFF_WAKE_FLAG 4'h5
`define LPC_OFF_WAKE_EDGE 4'h6
`define LPC_OFF_CLK_DIV 4'h7
`define LPC_OFF_MODE_CTRL 4'h8
`define LPC_OFF_STATUS 4'h9
`define LPC_STOP_RESET 32'hFFFFFFFF
`define LPC_STOP_C_RESET 32'hFFFFFFFE
`define LPC_BIT_TIMER_STOP 9
`define LPC_BIT_USB_STOP 19
`define LPC_BIT_RAM_STOP 0
`define LPC_BIT_SDA 0
`define LPC_BIT_SCL 1
`define LPC_BIT_USB 2
`define LPC_BIT_BCLK_HIGH 0
`define LPC_BIT_STBY_SEL 1
`define LPC_BIT_DEEP_EN 2
`define LPC_BIT_ALLSTOP 3
`define LPC_OPC_LSB 4
`define LPC_BIT_MAIN_STBY 6
`define LPC_BIT_SUB_STBY 7
`define LPC_DEEP_CUT_LSB 0
`define LPC_RAM_TOP 32'h0000FFFF
`define LPC_DIV_W 4
`endif

// file: hdl/lpc_pkg.sv
// types shared by the low power controller
package lpc_pkg;
  typedef enum logic [2:0] {
    LPC_RUN = 3'b000,
    LPC_SLEEP = 3'b001,
    LPC_ALLSTOP = 3'b011,
    LPC_STBY = 3'b010,
    LPC_DEEP = 3'b110
  } lpc_mode_t;
  typedef struct packed {
    logic cpuRun;
    logic periphRun;
    logic ramRun;
    logic flashRun;
    logic usbRun;
    logic usbPowered;
    logic timerRun;
    logic timerPowered;
    logic watchdogAllowed;
    logic ramPowered;
    logic fastOscRun;
    logic slowOscRun;
    logic pllRun;
    logic mainOscRun;
    logic subOscRun;
    logic detectorAllowed;
    logic portHold;
  } lpc_unit_t;
  typedef struct packed {
    logic [3:0] sysDiv;
    logic [3:0] perDiv;
    logic [3:0] busDiv;
    logic [3:0] flashDiv;
  } lpc_div_t;
endpackage : lpc_pkg

// file: hdl/low_power_mode_controller.sv
// low power mode controller: clock dividers, module stops, mode sequencer, deep wake sources
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_low_power_mode_controller (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [`LPC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic standbyInstr,
  input wire logic wakeIrq,
  input wire logic usbResume,
  input wire logic serial_data_wake_pin,
  input wire logic serial_clock_wake_pin,
  input wire logic busClkIn,
  output logic busClkPin,
  output lpc_pkg::lpc_div_t clkDiv,
  output logic [1:0] operating_power_control,
  output logic [31:0] stopA,
  output logic [31:0] stopB,
  output logic [31:0] stopC,
  output lpc_pkg::lpc_unit_t unitCtrl,
  output lpc_pkg::lpc_mode_t modeState,
  output logic wakeToIrq,
  output logic wakeToReset,
  output logic [31:0] ramStopTop
);
  import lpc_pkg::*;

  // bus-written module stops, kept across every low power mode
  logic [31:0] stopA_q;
  logic [31:0] stopA_d;
  logic [31:0] stopB_q;
  logic [31:0] stopB_d;
  logic [31:0] stopC_q;
  logic [31:0] stopC_d;

  // deep standby control and the wake sources
  logic [7:0] deepCtrl_q;
  logic [7:0] deepCtrl_d;
  logic [7:0] wakeEn_q;
  logic [7:0] wakeEn_d;
  logic [7:0] wakeFlag_q;
  logic [7:0] wakeFlag_d;
  logic [7:0] wakeEdge_q;
  logic [7:0] wakeEdge_d;

  // clock dividers and mode selection
  lpc_div_t div_q;
  lpc_div_t div_d;
  logic [7:0] modeCtrl_q;
  logic [7:0] modeCtrl_d;

  // read data stands one cycle after the strobe
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // sequencer state, unit enables and wake pulses
  lpc_mode_t mode_q;
  lpc_mode_t mode_d;
  lpc_unit_t unit_q;
  lpc_unit_t unit_d;
  logic irqOut_q;
  logic irqOut_d;
  logic rstOut_q;
  logic rstOut_d;
  logic bclk_q;
  logic bclk_d;

  // ram range is fixed, held in a flop so the port is registered
  logic [31:0] ramTop_q;

  // pin synchronisers: stage one feeds stage two only
  logic [1:0] pinS1_q;
  logic [1:0] pinS2_q;
  logic [1:0] pinPrev_q;
  logic bclkS1_q;
  logic bclkS2_q;
  logic [1:0] pinEdge;
  logic [1:0] deepCut;
  logic [2:0] fire;

  // pins and the bus clock come from outside the clock domain
  // two stages before any logic; the third stage only marks edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinS1_q <= 2'h0;
      pinS2_q <= 2'h0;
      pinPrev_q <= 2'h0;
      bclkS1_q <= 1'b0;
      bclkS2_q <= 1'b0;
    end else if (clkEn) begin
      pinS1_q <= {serial_clock_wake_pin, serial_data_wake_pin};
      pinS2_q <= pinS1_q;
      pinPrev_q <= pinS2_q;
      bclkS1_q <= busClkIn;
      bclkS2_q <= bclkS1_q;
    end
  end

  // deep cut: bit 0 drops ram, bit 1 drops usb resume detection
  assign deepCut = deepCtrl_q[`LPC_DEEP_CUT_LSB +: 2];

  // each pin has its own detector; the bit index equals the pin index
  // edge select: 0 falling, 1 rising, seen after the second sync stage
  for (genvar p = 0; p < 2; p++) begin : g_pinWake
    logic rise;
    logic fall;
    assign rise = pinS2_q[p] & ~pinPrev_q[p];
    assign fall = ~pinS2_q[p] & pinPrev_q[p];
    assign pinEdge[p] = wakeEdge_q[p] ? rise : fall;
    assign fire[p] = pinEdge[p] & wakeEn_q[p];
  end

  // usb resume only counts while deep cut keeps the detector alive
  assign fire[`LPC_BIT_USB] = usbResume & wakeEn_q[`LPC_BIT_USB] & ~deepCut[1];

  // register writes: only bus-written fields live here
  // writes to read-only or unmapped places are dropped
  always_comb begin
    stopA_d = stopA_q;
    stopB_d = stopB_q;
    stopC_d = stopC_q;
    deepCtrl_d = deepCtrl_q;
    wakeEn_d = wakeEn_q;
    wakeEdge_d = wakeEdge_q;
    div_d = div_q;
    modeCtrl_d = modeCtrl_q;
    if (regWr) begin
      case (regAddr)
        `LPC_OFF_STOP_A: stopA_d = regWdata;
        `LPC_OFF_STOP_B: stopB_d = regWdata;
        `LPC_OFF_STOP_C: stopC_d = regWdata;
        `LPC_OFF_DEEP_CTRL: deepCtrl_d = regWdata[7:0];
        `LPC_OFF_WAKE_EN: wakeEn_d = {5'h00, regWdata[2:0]};
        `LPC_OFF_WAKE_EDGE: wakeEdge_d = {6'h00, regWdata[1:0]};
        `LPC_OFF_CLK_DIV: div_d = regWdata[15:0];
        `LPC_OFF_MODE_CTRL: modeCtrl_d = regWdata[7:0];
        default: ;
      endcase
    end
  end

  // wake flags: software clears a flag by writing 0 to it
  always_comb begin
    wakeFlag_d = wakeFlag_q;
    if (regWr && (regAddr == `LPC_OFF_WAKE_FLAG)) begin
      wakeFlag_d = wakeFlag_q & {5'h00, regWdata[2:0]};
    end
    // flags only set while deep standby is held
    // set wins over a same-cycle clear so no wake cause is lost
    if (mode_q == LPC_DEEP) begin
      wakeFlag_d = wakeFlag_d | {5'h00, fire};
    end
  end

  // read mux; status reports the sequencer state
  // idle cycles return zero so several slaves could be or-ed
  always_comb begin
    rdata_d = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        `LPC_OFF_STOP_A: rdata_d = stopA_q;
        `LPC_OFF_STOP_B: rdata_d = stopB_q;
        `LPC_OFF_STOP_C: rdata_d = stopC_q;
        `LPC_OFF_DEEP_CTRL: rdata_d = {24'h000000, deepCtrl_q};
        `LPC_OFF_WAKE_EN: rdata_d = {24'h000000, wakeEn_q};
        `LPC_OFF_WAKE_FLAG: rdata_d = {24'h000000, wakeFlag_q};
        `LPC_OFF_WAKE_EDGE: rdata_d = {24'h000000, wakeEdge_q};
        `LPC_OFF_CLK_DIV: rdata_d = {16'h0000, div_q};
        `LPC_OFF_MODE_CTRL: rdata_d = {24'h000000, modeCtrl_q};
        `LPC_OFF_STATUS: rdata_d = {29'h00000000, mode_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // mode sequencer: selection latched at the standby instruction
  // deep standby takes priority over the other selections
  // an interrupt never ends deep standby; only enabled wake sources do
  // a mode is left for run only, never straight into another low power mode
  always_comb begin
    mode_d = mode_q;
    irqOut_d = 1'b0;
    rstOut_d = 1'b0;
    case (mode_q)
      LPC_RUN: begin
        if (standbyInstr) begin
          if (modeCtrl_q[`LPC_BIT_STBY_SEL] && modeCtrl_q[`LPC_BIT_DEEP_EN]) begin
            mode_d = LPC_DEEP;
          end else if (modeCtrl_q[`LPC_BIT_STBY_SEL]) begin
            mode_d = LPC_STBY;
          end else if (modeCtrl_q[`LPC_BIT_ALLSTOP]) begin
            mode_d = LPC_ALLSTOP;
          end else begin
            mode_d = LPC_SLEEP;
          end
        end
      end
      LPC_SLEEP, LPC_ALLSTOP, LPC_STBY: begin
        if (wakeIrq) begin
          mode_d = LPC_RUN;
          irqOut_d = 1'b1;
        end
      end
      LPC_DEEP: begin
        // deep wake restarts the cpu through reset, never via the interrupt
        if (|fire) begin
          mode_d = LPC_RUN;
          rstOut_d = 1'b1;
        end
      end
      default: mode_d = LPC_RUN;
    endcase
  end

  // unit enables per mode; units marked allowed still obey their own bits
  // computed from the next mode so the enables move together with modeState
  always_comb begin
    unit_d = '0;
    // detector and power-on reset stay alive in every mode
    unit_d.detectorAllowed = 1'b1;
    unit_d.mainOscRun = 1'b1;
    unit_d.subOscRun = 1'b1;
    unit_d.ramPowered = 1'b1;
    unit_d.usbPowered = 1'b1;
    unit_d.timerPowered = 1'b1;
    case (mode_d)
      // run and sleep: every unit but the cpu in sleep may run; ram, usb and timer follow their stop bits
      LPC_RUN, LPC_SLEEP: begin
        unit_d.cpuRun = (mode_d == LPC_RUN);
        unit_d.periphRun = 1'b1;
        unit_d.ramRun = ~stopC_d[`LPC_BIT_RAM_STOP];
        unit_d.flashRun = 1'b1;
        unit_d.usbRun = ~stopB_d[`LPC_BIT_USB_STOP];
        unit_d.timerRun = ~stopA_d[`LPC_BIT_TIMER_STOP];
        unit_d.watchdogAllowed = 1'b1;
        unit_d.fastOscRun = 1'b1;
        unit_d.slowOscRun = 1'b1;
        unit_d.pllRun = 1'b1;
      end
      LPC_ALLSTOP: begin
        // modules other than the timers, including ram and flash, frozen with contents kept; ports held
        unit_d.timerRun = ~stopA_d[`LPC_BIT_TIMER_STOP];
        unit_d.watchdogAllowed = 1'b1;
        unit_d.fastOscRun = 1'b1;
        unit_d.slowOscRun = 1'b1;
        unit_d.pllRun = 1'b1;
        unit_d.portHold = 1'b1;
      end
      // standby: fast and slow oscillators and the pll stop
      LPC_STBY: begin
        unit_d.watchdogAllowed = 1'b1;
        unit_d.mainOscRun = modeCtrl_d[`LPC_BIT_MAIN_STBY];
        unit_d.subOscRun = modeCtrl_d[`LPC_BIT_SUB_STBY];
        unit_d.portHold = 1'b1;
      end
      LPC_DEEP: begin
        // powered-down units lose state and need a restart
        unit_d.timerPowered = 1'b0;
        unit_d.ramPowered = ~deepCut[0];
        unit_d.usbPowered = ~deepCut[1];
        unit_d.mainOscRun = modeCtrl_d[`LPC_BIT_MAIN_STBY];
        unit_d.subOscRun = modeCtrl_d[`LPC_BIT_SUB_STBY];
        unit_d.portHold = 1'b1;
      end
      default: ;
    endcase
  end

  // bus clock pin: running clock or constant high
  always_comb begin
    bclk_d = modeCtrl_q[`LPC_BIT_BCLK_HIGH] ? 1'b1 : bclkS2_q;
  end

  // configuration registers, written only by the bus
  // a low clock enable leaves every field exactly as it was
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stopA_q <= `LPC_STOP_RESET;
      stopB_q <= `LPC_STOP_RESET;
      stopC_q <= `LPC_STOP_C_RESET;
      deepCtrl_q <= 8'h00;
      wakeEn_q <= 8'h00;
      wakeEdge_q <= 8'h00;
      div_q <= '0;
      modeCtrl_q <= 8'h00;
    end else if (clkEn) begin
      stopA_q <= stopA_d;
      stopB_q <= stopB_d;
      stopC_q <= stopC_d;
      deepCtrl_q <= deepCtrl_d;
      wakeEn_q <= wakeEn_d;
      wakeEdge_q <= wakeEdge_d;
      div_q <= div_d;
      modeCtrl_q <= modeCtrl_d;
    end
  end

  // ram range never changes; loaded at reset only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ramTop_q <= `LPC_RAM_TOP;
    end
  end

  // wake flags survive the deep wake so software can read the cause
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeFlag_q <= 8'h00;
    end else if (clkEn) begin
      wakeFlag_q <= wakeFlag_d;
    end
  end

  // read data register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (clkEn) begin
      rdata_q <= rdata_d;
    end
  end

  // sequencer state and wake pulses, one enabled cycle each
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= LPC_RUN;
      irqOut_q <= 1'b0;
      rstOut_q <= 1'b0;
    end else if (clkEn) begin
      mode_q <= mode_d;
      irqOut_q <= irqOut_d;
      rstOut_q <= rstOut_d;
    end
  end

  // unit enables registered so every output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unit_q <= '0;
    end else if (clkEn) begin
      unit_q <= unit_d;
    end
  end

  // bus clock pin starts high; it lags the source by the sync stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bclk_q <= 1'b1;
    end else if (clkEn) begin
      bclk_q <= bclk_d;
    end
  end

  // outputs, all registered
  // every port below is a flop or a slice of one
  // the pulses and read data last one cycle; stop, divider and power control outputs hold until rewritten
  assign regRdata = rdata_q;
  assign busClkPin = bclk_q;
  assign clkDiv = div_q;
  assign operating_power_control = modeCtrl_q[`LPC_OPC_LSB +: 2];
  assign stopA = stopA_q;
  assign stopB = stopB_q;
  assign stopC = stopC_q;
  assign unitCtrl = unit_q;
  assign modeState = mode_q;
  assign wakeToIrq = irqOut_q;
  assign wakeToReset = rstOut_q;
  assign ramStopTop = ramTop_q;
endmodule : lpc_low_power_mode_controller

// file: test/lpc_cpu_model.sv
// far-side model: cpu core issuing the standby instruction and wake interrupts
`timescale 1ns/1ps
module lpc_cpu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sleepReq,
  input wire logic wakeReq,
  output logic standbyInstr,
  output logic wakeIrq
);
  // instruction is one clock wide and comes after the mode register write
  always_ff @(posedge sys_clk) begin
    standbyInstr <= !rst && sleepReq;
    wakeIrq <= !rst && wakeReq;
  end
endmodule : lpc_cpu_model

// file: test/lpc_low_power_mode_controller_sva.sv
// port checker of the low power mode controller
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_low_power_mode_controller_sva
  import lpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [`LPC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic standbyInstr,
  input wire logic wakeIrq,
  input wire logic busClkPin,
  input wire logic [31:0] stopA,
  input wire lpc_unit_t unitCtrl,
  input wire lpc_mode_t modeState,
  input wire logic wakeToIrq,
  input wire logic wakeToReset,
  input wire logic [31:0] ramStopTop
);
  // a frozen clock enable holds all state, so checks pause with it
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clkEn);
  a_ram_range: assert property (ramStopTop == 32'h0000FFFF) else $error("ram range wrong");
  a_stop_write: assert property (regWr && regAddr == `LPC_OFF_STOP_A |=> stopA == $past(regWdata))
    else $error("stop bits not written");
  a_mode_entry: assert property (modeState == LPC_RUN && standbyInstr |=> modeState != LPC_RUN)
    else $error("standby ignored");
  a_irq_wake: assert property (modeState inside {LPC_SLEEP, LPC_ALLSTOP, LPC_STBY} && wakeIrq
    |=> modeState == LPC_RUN && wakeToIrq) else $error("no interrupt wake");
  a_irq_cause: assert property (wakeToIrq |-> !($past(modeState) inside {LPC_RUN, LPC_DEEP}))
    else $error("bad interrupt resume");
  a_reset_cause: assert property (wakeToReset |-> $past(modeState) == LPC_DEEP && modeState == LPC_RUN)
    else $error("bad reset resume");
  a_cpu_halt: assert property (modeState != LPC_RUN && $stable(modeState) |-> !unitCtrl.cpuRun)
    else $error("cpu runs in low power");
  a_deep_lost: assert property (modeState == LPC_DEEP && $stable(modeState)
    |-> !unitCtrl.timerPowered && !unitCtrl.watchdogAllowed) else $error("deep units powered");
  a_detector_kept: assert property (modeState != LPC_RUN && $stable(modeState) |-> unitCtrl.detectorAllowed)
    else $error("detector dropped");
  a_osc_stop: assert property (modeState inside {LPC_STBY, LPC_DEEP} && $stable(modeState)
    |-> !(unitCtrl.fastOscRun || unitCtrl.slowOscRun || unitCtrl.pllRun))
    else $error("oscillator runs in standby");
  c_deep_exit: cover property (modeState == LPC_DEEP ##1 modeState == LPC_RUN);
  c_irq_wake: cover property (wakeToIrq);
  c_bus_clock: cover property (busClkPin ##1 !busClkPin);
endmodule : lpc_low_power_mode_controller_sva

// file: test/tb_top.sv
// self-checking bench of the low power mode controller
`timescale 1ns/1ps
`include "lpc_defines.svh"
module tb_top;
  import lpc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic usbResume = 1'b0;
  logic serial_data_wake_pin = 1'b0;
  logic serial_clock_wake_pin = 1'b0;
  logic busClkIn = 1'b0;
  logic sleepReq = 1'b0;
  logic wakeReq = 1'b0;
  logic standbyInstr, wakeIrq, busClkPin, wakeToIrq, wakeToReset;
  logic [31:0] regRdata, stopA, stopB, stopC, ramStopTop, rd;
  logic [1:0] operating_power_control;
  lpc_div_t clkDiv;
  lpc_unit_t unitCtrl;
  lpc_mode_t modeState;
  logic [31:0] lfsr = 32'hAA7C;
  logic [31:0] expReg [16];
  int num_errors = 0;
  int tests_run = 0;
  // core clock and a slow unrelated bus clock source
  always #4 sys_clk = ~sys_clk;
  always #21 busClkIn = ~busClkIn;
  lpc_low_power_mode_controller lpc_low_power_mode_controller_i (.*);
  lpc_cpu_model lpc_cpu_model_i (.*);
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  // writable bits of each register; unmapped and status keep nothing
  function automatic logic [31:0] wmask(input logic [3:0] a);
    case (a)
      4'h0, 4'h1, 4'h2: wmask = 32'hFFFFFFFF;
      4'h3: wmask = 32'hFF;
      4'h6: wmask = 32'h3;
      4'h4: wmask = 32'h7;
      4'h7: wmask = 32'hFFFF;
      4'h8: wmask = 32'hFF;
      default: wmask = 32'h0;
    endcase
  endfunction : wmask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_mode(input lpc_mode_t exp);
    tests_run++;
    if (modeState !== exp) begin
      num_errors++;
      $display("[FAIL] %0t mode %b expected %b", $time, modeState, exp);
    end
  endtask : check_mode
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    expReg[a] = d & wmask(a);
  endtask : bus_write
  // data stands only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    check_word(regRdata, expReg[a]);
    @(posedge sys_clk);
  endtask : chk_reg
  task automatic wait_pulse(input logic sel);
    int n;
    n = 0;
    while ((sel ? wakeToReset : wakeToIrq) !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 20) begin
        num_errors++;
        $display("[FAIL] %0t no wake pulse", $time);
        stop_test();
      end
    end
  endtask : wait_pulse
  // instruction after the mode write; unit enables settle a cycle later
  task automatic enter(input lpc_mode_t exp);
    sleepReq <= 1'b1;
    @(posedge sys_clk);
    sleepReq <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check_mode(exp);
  endtask : enter
  initial begin
    for (int i = 0; i < 16; i++) expReg[i] = 32'h0;
    expReg[0] = `LPC_STOP_RESET;
    expReg[1] = `LPC_STOP_RESET;
    expReg[2] = `LPC_STOP_C_RESET;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 16; a++) if (a != 5) chk_reg(4'(a));
    // random traffic, including read-only and unmapped places
    for (int k = 0; k < 3; k++) begin
      for (int a = 0; a < 16; a++) begin
        if (a == 5) continue;
        lfsr = next_rand(lfsr);
        bus_write(4'(a), lfsr);
        chk_reg(4'(a));
      end
      check_word(stopB, expReg[1]);
      check_word(stopC, expReg[2]);
      check_word({16'h0, clkDiv}, expReg[7]);
      check_word({30'h0, operating_power_control}, {30'h0, expReg[8][5:4]});
    end
    bus_write(4'h8, 32'h1);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      check_word({31'h0, busClkPin}, 32'h1);
    end
    bus_write(4'h8, 32'h0);
    rd = 32'h0;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (busClkPin === 1'b0) rd = 32'h1;
    end
    check_word(rd, 32'h1);
    // sleep, all-module stop and standby, each with an interrupt wake
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      bus_write(4'h8, m == 0 ? 32'h10 : (m == 1 ? 32'h28 : 32'h02));
      enter(m == 0 ? LPC_SLEEP : (m == 1 ? LPC_ALLSTOP : LPC_STBY));
      check_word({30'h0, operating_power_control}, {30'h0, expReg[8][5:4]});
      if (m == 2) check_word({30'h0, unitCtrl.portHold, unitCtrl.pllRun}, 32'h2);
      @(posedge sys_clk);
      wakeReq <= 1'b1;
      wait_pulse(1'b0);
      check_mode(LPC_RUN);
      @(posedge sys_clk);
      wakeReq <= 1'b0;
    end
    // deep standby: disabled clock pin must not wake, enabled data pin must
    bus_write(4'h4, 32'h1);
    bus_write(4'h6, 32'h3);
    bus_write(4'h3, 32'h0);
    bus_write(4'h8, 32'h06);
    enter(LPC_DEEP);
    check_word({28'h0, unitCtrl.timerPowered, unitCtrl.watchdogAllowed, unitCtrl.detectorAllowed, unitCtrl.ramPowered},
      32'h3);
    @(posedge sys_clk);
    serial_clock_wake_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check_mode(LPC_DEEP);
    @(posedge sys_clk);
    serial_data_wake_pin <= 1'b1;
    wait_pulse(1'b1);
    check_mode(LPC_RUN);
    @(posedge sys_clk);
    expReg[5] = 32'h1;
    chk_reg(4'h5);
    // second deep entry: ram cut, usb resume wakes
    bus_write(4'h4, 32'h4);
    bus_write(4'h3, 32'h1);
    bus_write(4'h5, 32'h0);
    enter(LPC_DEEP);
    check_word({31'h0, unitCtrl.ramPowered}, 32'h0);
    @(posedge sys_clk);
    usbResume <= 1'b1;
    wait_pulse(1'b1);
    usbResume <= 1'b0;
    expReg[5] = 32'h4;
    chk_reg(4'h5);
    // frozen clock enable: a write must be dropped
    rd = expReg[0];
    clkEn <= 1'b0;
    bus_write(4'h0, 32'h00001234);
    clkEn <= 1'b1;
    expReg[0] = rd;
    chk_reg(4'h0);
    check_word(stopA, rd);
    stop_test();
  end
endmodule : tb_top
bind lpc_low_power_mode_controller lpc_low_power_mode_controller_sva lpc_low_power_mode_controller_sva_i (.*);
